// [pmc_top.v]
// protected ram/register map control with apb access and decode probe
//
// Chosen here: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "pmc_defines.vh"
// Function
// - protected writes: first 64 cycles, once
// - special mode disables write protection
// - ram page field is ram base digit
// - register page field resets to one
// - internal reads ignore external data pins
// - registers beat ram, ram beats rom
// - unused register slot returns undriven bus
// - expanded mode passes slots two-seven external
module pmc_top #(
	parameter WINDOW = 64,
	parameter [7:0] FLOAT_VALUE = 8'hFF,
	parameter [63:0] SLOT_USED = 64'hFFFF_FFFF_FFFF_FFFF
) (
	input wire SYS_CLK_IN,
	input wire RST_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [7:0] EXT_DATA_IN,
	input wire [7:0] INT_DATA_IN,
	output wire PREADY_OUT,
	output wire PSLVERR_OUT,
	output reg [31:0] PRDATA_OUT,
	output wire [3:0] RAM_PAGE_OUT,
	output wire [3:0] REG_PAGE_OUT,
	output wire SPECIAL_MODE_OUT
);
	// ===========================================
	// state
	reg [7:0] map;
	reg [2:0] ctrl;
	reg [15:0] sample_addr;
	reg [7:0] sample_data;
	reg [2:0] sample_sel;
	wire special_mode_flag = ctrl[`PMC_CTRL_SPECIAL];
	wire setup = PSEL_IN & ~PENABLE_IN;
	wire access = PSEL_IN & PENABLE_IN;
	wire wr = access & PWRITE_IN;
	wire map_wr = wr && (PADDR_IN == `PMC_OFS_MAP);
	wire allow;
	wire window_open;
	wire used;
	wire [2:0] probe_sel;
	wire mapped = (PADDR_IN == `PMC_OFS_MAP) || (PADDR_IN == `PMC_OFS_CTRL) ||
		(PADDR_IN == `PMC_OFS_STAT) || (PADDR_IN == `PMC_OFS_SAMPLE) ||
		(PADDR_IN == `PMC_OFS_PROT);
	assign PREADY_OUT = 1'b1;
	assign PSLVERR_OUT = access & ~mapped;
	assign RAM_PAGE_OUT = map[7:4];
	assign REG_PAGE_OUT = map[3:0];
	assign SPECIAL_MODE_OUT = special_mode_flag;
	// ===========================================
	// protection and decode
	pmc_guard #(.WINDOW(WINDOW)) u_guard (
		.clk(SYS_CLK_IN),
		.rst(RST_IN),
		.special(special_mode_flag),
		.wr_stb(map_wr),
		.allow(allow),
		.window_open(window_open),
		.used(used)
	);
	pmc_decode u_decode (
		.addr(sample_addr),
		.ram_page(map[7:4]),
		.reg_page(map[3:0]),
		.expanded(ctrl[`PMC_CTRL_EXPANDED]),
		.rom_on(ctrl[`PMC_CTRL_ROM_ON]),
		.slot_used(SLOT_USED),
		.sel(probe_sel)
	);
	// register writes; map only when protection allows
	always @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			map <= `PMC_MAP_RESET;
			ctrl <= 3'h0;
			sample_addr <= 16'h0000;
		end else if (wr) begin
			if (PADDR_IN == `PMC_OFS_MAP && allow)
				map <= PWDATA_IN[7:0];
			if (PADDR_IN == `PMC_OFS_CTRL)
				ctrl <= PWDATA_IN[2:0];
			if (PADDR_IN == `PMC_OFS_SAMPLE)
				sample_addr <= PWDATA_IN[15:0];
		end
	end
	// data source for the probed address
	always @(posedge SYS_CLK_IN) begin
		if (RST_IN) begin
			sample_data <= 8'h00;
			sample_sel <= `PMC_SEL_NONE;
		end else begin
			sample_sel <= probe_sel;
			case (probe_sel)
				`PMC_SEL_REG, `PMC_SEL_RAM, `PMC_SEL_ROM: begin
					sample_data <= INT_DATA_IN;
				end
				`PMC_SEL_HOLE: begin
					sample_data <= FLOAT_VALUE;
				end
				`PMC_SEL_EXT, `PMC_SEL_NONE: begin
					sample_data <= EXT_DATA_IN;
				end
				default: begin
					sample_data <= 8'h00;
				end
			endcase
		end
	end
	// read data registered in setup so it is valid in access
	always @(posedge SYS_CLK_IN) begin
		if (RST_IN)
			PRDATA_OUT <= 32'h0000_0000;
		else if (setup && !PWRITE_IN) begin
			case (PADDR_IN)
				`PMC_OFS_MAP: PRDATA_OUT <= {24'h000000, map};
				`PMC_OFS_CTRL: PRDATA_OUT <= {29'h00000000, ctrl};
				`PMC_OFS_STAT: PRDATA_OUT <= {21'h000000, sample_sel, sample_data};
				`PMC_OFS_SAMPLE: PRDATA_OUT <= {16'h0000, sample_addr};
				`PMC_OFS_PROT: PRDATA_OUT <= {29'h00000000, used, window_open, allow};
				default: PRDATA_OUT <= 32'h0000_0000;
			endcase
		end
	end
endmodule // pmc_top

// [pmc_defines.vh]
// constants for the protected map control block
`ifndef PMC_DEFINES_VH
`define PMC_DEFINES_VH
// apb register byte offsets
`define PMC_OFS_MAP 12'h000
`define PMC_OFS_CTRL 12'h004
`define PMC_OFS_STAT 12'h008
`define PMC_OFS_SAMPLE 12'h00C
`define PMC_OFS_PROT 12'h010
// map register reset value: ram page 0, register page 1
`define PMC_MAP_RESET 8'h01
// control register bits
`define PMC_CTRL_SPECIAL 0
`define PMC_CTRL_EXPANDED 1
`define PMC_CTRL_ROM_ON 2
// protection window length in bus cycles
`define PMC_WINDOW_CYCLES 7'h40
// register block slot range passed to external bus
`define PMC_EXT_LO 6'h02
`define PMC_EXT_HI 6'h07
// decode result codes
`define PMC_SEL_NONE 3'h0
`define PMC_SEL_REG 3'h1
`define PMC_SEL_RAM 3'h2
`define PMC_SEL_ROM 3'h3
`define PMC_SEL_EXT 3'h4
`define PMC_SEL_HOLE 3'h5
// rom window page boundary (top 8 kbyte)
`define PMC_ROM_BASE 3'h7
`endif

// [pmc_guard.v]
// write protection window and write-once tracking
`timescale 1ns/1ps
`include "pmc_defines.vh"
module pmc_guard #(
	parameter WINDOW = 64
) (
	input wire clk,
	input wire rst,
	input wire special,
	input wire wr_stb,
	output wire allow,
	output reg window_open,
	output reg used
);
	reg [6:0] count;
	// window counts bus cycles after reset
	always @(posedge clk) begin
		if (rst) begin
			count <= 7'h00;
			window_open <= 1'b1;
			used <= 1'b0;
		end else begin
			if (window_open) begin
				count <= count + 7'h01;
				if (count == WINDOW[6:0] - 7'h01)
					window_open <= 1'b0;
			end
			if (wr_stb && allow && !special)
				used <= 1'b1;
		end
	end
	// special mode lifts protection
	assign allow = special | (window_open & ~used);
endmodule // pmc_guard

// [pmc_decode.v]
// address decode with overlap priority
`timescale 1ns/1ps
`include "pmc_defines.vh"
module pmc_decode (
	input wire [15:0] addr,
	input wire [3:0] ram_page,
	input wire [3:0] reg_page,
	input wire expanded,
	input wire rom_on,
	input wire [63:0] slot_used,
	output reg [2:0] sel
);
	wire reg_hit = (addr[15:12] == reg_page) && (addr[11:6] == 6'h00);
	wire ram_hit = (addr[15:12] == ram_page) && (addr[11:8] == 4'h0);
	wire rom_hit = rom_on && (addr[15:13] == `PMC_ROM_BASE);
	wire ext_slot = expanded && (addr[5:0] >= `PMC_EXT_LO) && (addr[5:0] <= `PMC_EXT_HI);
	// register space beats ram, ram beats rom
	always @* begin
		if (reg_hit) begin
			if (ext_slot)
				sel = `PMC_SEL_EXT;
			else if (slot_used[addr[5:0]])
				sel = `PMC_SEL_REG;
			else
				sel = `PMC_SEL_HOLE;
		end else if (ram_hit)
			sel = `PMC_SEL_RAM;
		else if (rom_hit)
			sel = `PMC_SEL_ROM;
		else
			sel = `PMC_SEL_NONE;
	end
endmodule // pmc_decode

// [pmc_cpu_model.sv]
// far side data sources for the map control block
`timescale 1ns/1ps
module pmc_cpu_model (
	output wire [7:0] int_data_out,
	output wire [7:0] ext_data_out
);
// external pins stay driven during internal reads
assign int_data_out = 8'hC3;
assign ext_data_out = 8'h3C;
endmodule // pmc_cpu_model

// [pmc_checker.sv]
// port assertions for the map control block
`timescale 1ns/1ps
module pmc_checker #(
	parameter WINDOW = 64
) (
	input wire SYS_CLK_IN,
	input wire RST_IN,
	input wire PSEL_IN,
	input wire PENABLE_IN,
	input wire PWRITE_IN,
	input wire [11:0] PADDR_IN,
	input wire [31:0] PWDATA_IN,
	input wire [7:0] EXT_DATA_IN,
	input wire [7:0] INT_DATA_IN,
	input wire PSLVERR_OUT,
	input wire [31:0] PRDATA_OUT,
	input wire [3:0] RAM_PAGE_OUT,
	input wire [3:0] REG_PAGE_OUT,
	input wire SPECIAL_MODE_OUT
);
reg [7:0] cnt;
reg used;
wire acc = PSEL_IN && PENABLE_IN;
wire mw = acc && PWRITE_IN && PADDR_IN == 12'h000;
wire nw = mw && !SPECIAL_MODE_OUT;
wire [7:0] wd = PWDATA_IN[7:0];
wire [7:0] pg = {RAM_PAGE_OUT, REG_PAGE_OUT};
wire [2:0] sel = PRDATA_OUT[10:8];
// cycles since reset and write-once use
always @(posedge SYS_CLK_IN) begin
	if (RST_IN) begin
		cnt <= 8'h00;
		used <= 1'b0;
	end else begin
		if (cnt != 8'hFF)
			cnt <= cnt + 8'h01;
		if (nw)
			used <= 1'b1;
	end
end
// ==========
// checks
default clocking @(posedge SYS_CLK_IN); endclocking
default disable iff (RST_IN);
sequence s_late; nw && (used || cnt > WINDOW + 1); endsequence
sequence s_stat; PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == 12'h008; endsequence
chk_page_reset: assert property ($fell(RST_IN) |-> pg == 8'h01)
	else $error("map not at reset value");
chk_first_write: assert property (nw && !used && cnt < WINDOW - 2 |=> pg == $past(wd))
	else $error("early map write lost");
chk_late_drop: assert property (s_late |=> $stable(pg))
	else $error("late map write taken");
chk_special_write: assert property (mw && SPECIAL_MODE_OUT |=> pg == $past(wd))
	else $error("special map write lost");
chk_map_read: assert property (PSEL_IN && !PENABLE_IN && !PWRITE_IN && PADDR_IN == 12'h000
	|=> PRDATA_OUT == {24'h000000, pg})
	else $error("map readback wrong");
chk_int_data: assert property (s_stat |=> sel inside {1, 2, 3} |-> PRDATA_OUT[7:0] == INT_DATA_IN)
	else $error("internal hit took pins");
chk_ext_data: assert property (s_stat |=> sel == 3'h4 |-> PRDATA_OUT[7:0] == EXT_DATA_IN)
	else $error("slot not external");
chk_map_silent: assert property (acc && PADDR_IN == 12'h000 |-> !PSLVERR_OUT)
	else $error("map access flagged");
endmodule // pmc_checker
bind pmc_top pmc_checker #(.WINDOW(WINDOW)) pmc_checker_i (.*);

// [pmc_top_tb.sv]
// testbench for the map control block
`timescale 1ns/1ps
module pmc_top_tb;
reg c = 0, rs = 1, ps = 0, pe = 0, pw = 0;
reg [11:0] pa = 0;
reg [31:0] wd = 0, r;
reg e;
wire [3:0] rp, gp;
wire rdy, er;
wire [31:0] rd;
wire [7:0] id, ed;
integer err_count = 0, comparisons = 0, t = 0;
always #5 c = ~c;
pmc_cpu_model pmc_cpu_model_i (.int_data_out(id), .ext_data_out(ed));
// slot 0x35 left unused so the hole path is reachable
pmc_top #(.WINDOW(16), .SLOT_USED(64'hFFDF_FFFF_FFFF_FFFF)) pmc_top_i (.SYS_CLK_IN(c),
	.RST_IN(rs), .PSEL_IN(ps), .PENABLE_IN(pe),
	.PWRITE_IN(pw), .PADDR_IN(pa), .PWDATA_IN(wd), .EXT_DATA_IN(ed), .INT_DATA_IN(id),
	.PREADY_OUT(rdy), .PSLVERR_OUT(er), .PRDATA_OUT(rd), .RAM_PAGE_OUT(rp), .REG_PAGE_OUT(gp),
	.SPECIAL_MODE_OUT());
task final_report;
	$display("errors %0d compares %0d", err_count, comparisons);
	if (err_count == 0 && comparisons > 0)
		$display("DONE - PASS");
	else
		$display("DONE - FAIL");
	$finish;
endtask
task ck(input [31:0] g, input [31:0] e);
	comparisons = comparisons + 1;
	if (g !== e) begin
		err_count = err_count + 1;
		$display("BAD t=%0t got %h exp %h", $time, g, e);
	end
endtask
// one apb transfer, held until pready
task xf(input [11:0] a, input [31:0] d, input w);
	@(posedge c);
	ps <= 1;
	pa <= a;
	wd <= d;
	pw <= w;
	@(posedge c);
	pe <= 1;
	do @(posedge c); while (rdy !== 1'b1);
	r = rd;
	e = er;
	ps <= 0;
	pe <= 0;
endtask
// probe an address and compare the status word
task pr(input [15:0] a, input [31:0] e);
	xf(12'h00C, {16'h0000, a}, 1);
	@(posedge c);
	xf(12'h008, 0, 0);
	ck(r, e);
endtask
// cut a hang short
always @(posedge c) begin
	t = t + 1;
	if (t == 3000) begin
		err_count = err_count + 1;
		final_report;
	end
end
initial begin
	repeat (6) @(posedge c);
	rs <= 0;
	xf(0, 32'h5A, 1);
	xf(0, 32'h33, 1);
	xf(0, 0, 0);
	ck(r, 32'h5A);
	pr(16'h5000, 32'h2C3);
	pr(16'hA010, 32'h1C3);
	pr(16'h0000, 32'h03C);
	xf(4, 2, 1);
	pr(16'hA003, 32'h43C);
	xf(4, 1, 1);
	xf(0, 32'hFF, 1);
	xf(0, 32'hEE, 1);
	xf(0, 0, 0);
	ck(r, 32'hEE);
	xf(4, 5, 1);
	pr(16'hE010, 32'h1C3);
	pr(16'hE080, 32'h2C3);
	pr(16'hE200, 32'h3C3);
	pr(16'hE035, 32'h5FF);
	xf(4, 7, 1);
	pr(16'hE005, 32'h43C);
	xf(4, 0, 1);
	xf(0, 32'h11, 1);
	xf(0, 0, 0);
	ck(r, 32'hEE);
	ck({24'h000000, rp, gp}, 32'hEE);
	xf(12'h014, 0, 0);
	ck({31'h00000000, e}, 32'h1);
	xf(12'h010, 0, 0);
	ck({31'h00000000, e}, 32'h0);
	final_report;
end
endmodule // pmc_top_tb
